// *** logic/sfsq_pkg.sv ***
// Package for the soft-start and fault protection sequencer
package sfsq_pkg;

    // ==========================================================
    // Timing counts and widths
    localparam int unsigned RAMP_PERIODS    = 2048;
    localparam int unsigned DVID_TAIL_CYC   = 32;
    localparam int unsigned UV_QUAL_CYC     = 1;
    localparam int unsigned REF_W           = 12;
    localparam int unsigned VID_W           = 8;
    localparam int unsigned MODE_W          = 2;
    localparam int unsigned PHASES          = 3;

    // ==========================================================
    // Mode strap encodings
    localparam logic [1:0] MODE_GROUNDED    = 2'h0;
    localparam logic [1:0] MODE_STRAP_82K   = 2'h1;
    localparam logic [1:0] MODE_OPEN        = 2'h2;

    // ==========================================================
    // Reset values
    localparam logic [REF_W-1:0] REF_RST    = 12'h000;

    // ==========================================================
    // Sequencer states
    typedef enum logic [3:0] {
        SFSQ_IDLE  = 4'b0001,
        SFSQ_RAMP  = 4'b0010,
        SFSQ_RUN   = 4'b0100,
        SFSQ_FAULT = 4'b1000
    } sfsq_state_t;

    // ==========================================================
    // Comparator results from the analog front end
    typedef struct packed {
        logic under_voltage_trip;
        logic over_voltage_trip;
        logic over_230mv_low;
        logic remote_above_1v9;
        logic remote_below_1v6;
        logic remote_above_2v1;
        logic remote_below_1v8;
        logic feedback_open;
    } sfsq_cmp_t;

    // ==========================================================
    // Sticky fault latches
    typedef struct packed {
        logic uv;
        logic ov;
        logic fb;
    } sfsq_fault_t;

endpackage

// *** logic/sfsq_seq.sv ***
// Soft-start ramp, start-up low-side hold and latched fault protection
`timescale 1ns/100ps

module sfsq_seq
    import sfsq_pkg::*;
#(
    parameter int unsigned RAMP_LEN = RAMP_PERIODS,
    parameter int unsigned TAIL_LEN = DVID_TAIL_CYC
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    // Supply and enable status
    input  wire logic                supply_turnon_threshold,
    input  wire logic                preprotect_supply_threshold,
    input  wire logic                enable_released,
    // Configuration
    input  wire logic [MODE_W-1:0]   mode_strap,
    input  wire logic [VID_W-1:0]    vid_code,
    input  wire logic [REF_W-1:0]    target_ref,
    input  wire logic [REF_W-1:0]    uv_enable_ref,
    // Loop and comparator inputs
    input  wire logic                dynamic_reference_step,
    input  wire logic [PHASES-1:0]   loop_high_side,
    input  wire logic [PHASES-1:0]   loop_low_side,
    input  wire sfsq_cmp_t           cmp,
    // Outputs
    output logic [REF_W-1:0]         ref_level,
    output logic [MODE_W-1:0]        mode_held,
    output logic [VID_W-1:0]         vid_held,
    output logic [PHASES-1:0]        high_side_switch,
    output logic [PHASES-1:0]        low_side_switch,
    output logic                     lowside_hold_startup,
    output logic                     ramp_done_power_good_o,
    output logic                     ramp_done_power_good_oe,
    output logic                     fault_out,
    output sfsq_fault_t              fault_latched
);

    // ==========================================================
    // Internal state
    sfsq_state_t       state_reg;
    logic [11:0]       ramp_cnt_reg;
    logic [5:0]        mask_cnt_reg;
    logic              uv_seen_reg;
    logic              preov_reg;
    logic              uv_armed_reg;
    logic              run_ok;
    logic              masked;
    logic              ov_hit;
    logic              preov_on;
    logic              preov_off;
    logic              nondefault;
    logic [REF_W+11:0] ramp_prod;

    assign run_ok     = supply_turnon_threshold && enable_released;
    assign masked     = dynamic_reference_step || (mask_cnt_reg != 6'h00);
    assign ov_hit     = cmp.over_voltage_trip && !masked;
    assign nondefault = (mode_held != MODE_GROUNDED);
    assign ramp_prod  = target_ref * ramp_cnt_reg;

    // ==========================================================
    // Sequencer state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= SFSQ_IDLE;
        end else if (!run_ok) begin
            state_reg <= SFSQ_IDLE;
        end else begin
            case (state_reg)
                SFSQ_IDLE: begin
                    state_reg <= SFSQ_RAMP;
                end
                SFSQ_RAMP: begin
                    if (|fault_latched) begin
                        state_reg <= SFSQ_FAULT;
                    end else if (ramp_cnt_reg == 12'(RAMP_LEN - 1)) begin
                        state_reg <= SFSQ_RUN;
                    end
                end
                SFSQ_RUN: begin
                    if (|fault_latched) begin
                        state_reg <= SFSQ_FAULT;
                    end
                end
                SFSQ_FAULT: begin
                    state_reg <= SFSQ_FAULT;
                end
                default: begin
                    state_reg <= SFSQ_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Reference ramp
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ramp_cnt_reg <= 12'h000;
            ref_level    <= REF_RST;
        end else if (state_reg == SFSQ_RAMP) begin
            ramp_cnt_reg <= ramp_cnt_reg + 12'h001;
            ref_level    <= REF_W'(ramp_prod / RAMP_LEN);
        end else if (state_reg == SFSQ_RUN) begin
            ref_level    <= target_ref;
        end else begin
            ramp_cnt_reg <= 12'h000;
            ref_level    <= REF_RST;
        end
    end

    // ==========================================================
    // Table selection freeze
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_held <= MODE_GROUNDED;
            vid_held  <= '0;
        end else if (state_reg == SFSQ_IDLE) begin
            mode_held <= mode_strap;
            vid_held  <= vid_code;
        end
    end

    // ==========================================================
    // Step mask tail
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_cnt_reg <= 6'h00;
        end else if (dynamic_reference_step) begin
            mask_cnt_reg <= 6'(TAIL_LEN);
        end else if (mask_cnt_reg != 6'h00) begin
            mask_cnt_reg <= mask_cnt_reg - 6'h01;
        end
    end

    // ==========================================================
    // Under-voltage arming and qualification
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            uv_armed_reg <= 1'b0;
            uv_seen_reg  <= 1'b0;
        end else begin
            if (state_reg == SFSQ_IDLE) begin
                uv_armed_reg <= 1'b0;
            end else if (ref_level >= uv_enable_ref) begin
                uv_armed_reg <= 1'b1;
            end
            uv_seen_reg <= uv_armed_reg && !masked
                           && cmp.under_voltage_trip;
        end
    end

    // ==========================================================
    // Sticky fault latches
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_latched <= '0;
        end else if (!run_ok) begin
            fault_latched <= '0;
        end else if (state_reg != SFSQ_IDLE) begin
            if (uv_seen_reg && cmp.under_voltage_trip && !masked) begin
                fault_latched.uv <= 1'b1;
            end
            if (ov_hit) begin
                fault_latched.ov <= 1'b1;
            end
            if (cmp.feedback_open) begin
                fault_latched.fb <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Preliminary over-voltage with hysteresis
    always_comb begin
        if (mode_strap == MODE_GROUNDED) begin
            preov_on  = cmp.remote_above_2v1;
            preov_off = cmp.remote_below_1v8;
        end else begin
            preov_on  = cmp.remote_above_1v9;
            preov_off = cmp.remote_below_1v6;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            preov_reg <= 1'b0;
        end else if (!preprotect_supply_threshold
                     || supply_turnon_threshold) begin
            preov_reg <= 1'b0;
        end else if (preov_on) begin
            preov_reg <= 1'b1;
        end else if (preov_off) begin
            preov_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Start-up low-side hold
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lowside_hold_startup <= 1'b0;
        end else if (state_reg != SFSQ_RAMP) begin
            lowside_hold_startup <= (state_reg == SFSQ_IDLE) && run_ok;
        end else if (|loop_high_side) begin
            lowside_hold_startup <= 1'b0;
        end
    end

    // ==========================================================
    // Gate drive outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_side_switch <= '0;
            low_side_switch  <= '0;
        end else if (preov_reg) begin
            high_side_switch <= '0;
            low_side_switch  <= '1;
        end else if (fault_latched.ov || fault_latched.fb || ov_hit
                     || cmp.feedback_open) begin
            high_side_switch <= '0;
            low_side_switch  <= '1;
        end else if (fault_latched.uv
                     || (state_reg != SFSQ_RAMP
                         && state_reg != SFSQ_RUN)) begin
            high_side_switch <= '0;
            low_side_switch  <= '0;
        end else begin
            high_side_switch <= loop_high_side;
            low_side_switch  <= lowside_hold_startup
                                ? '0 : loop_low_side;
        end
    end

    // ==========================================================
    // Fault pin and power-good
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_out               <= 1'b0;
            ramp_done_power_good_o  <= 1'b0;
            ramp_done_power_good_oe <= 1'b1;
        end else begin
            fault_out              <= |fault_latched;
            ramp_done_power_good_o <= 1'b0;
            if (state_reg == SFSQ_RUN && !(|fault_latched)) begin
                ramp_done_power_good_oe <= nondefault && !masked
                                           && cmp.over_230mv_low;
            end else begin
                ramp_done_power_good_oe <= 1'b1;
            end
        end
    end

endmodule

// *** test/sfsq_partner.sv ***
// Supply, enable and pull-up model of the far side
`timescale 1ns/100ps
module sfsq_partner (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Requested supply stage and pin drive
    input  wire logic [1:0] stage_max,
    input  wire logic       pg_o,
    input  wire logic       pg_oe,
    // Supply, enable and pin level
    output logic            pre_ok,
    output logic            supply_ok,
    output logic            enable_ok,
    output wire logic       pg_pin
);
    logic [1:0] stage_reg;
    // Supplies rise one step a clock, enable last
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_reg <= 2'h0;
        end else if (stage_reg < stage_max) begin
            stage_reg <= stage_reg + 2'h1;
        end else if (stage_reg > stage_max) begin
            stage_reg <= stage_reg - 2'h1;
        end
    end
    assign pre_ok    = stage_reg >= 2'h1;
    assign supply_ok = stage_reg >= 2'h2;
    assign enable_ok = stage_reg == 2'h3;
    assign pg_pin    = pg_oe ? pg_o : 1'b1;
endmodule

// *** test/sfsq_seq_properties.sv ***
// Port checker of the soft-start and fault sequencer
`timescale 1ns/100ps
module sfsq_seq_chk
    import sfsq_pkg::*;
(
    // Clock, reset and inputs
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic              supply_turnon_threshold,
    input wire logic              enable_released,
    input wire logic              dynamic_reference_step,
    input wire sfsq_cmp_t         cmp,
    input wire logic [REF_W-1:0]  target_ref,
    // Outputs
    input wire logic [REF_W-1:0]  ref_level,
    input wire logic [PHASES-1:0] high_side_switch,
    input wire logic [PHASES-1:0] low_side_switch,
    input wire logic              lowside_hold_startup,
    input wire logic              ramp_done_power_good_o,
    input wire logic              ramp_done_power_good_oe,
    input wire logic              fault_out,
    input wire sfsq_fault_t       fault_latched
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // ==========================================
    // Properties
    uv_off_a: assert property (
        fault_latched.uv && $past(fault_latched.uv, 2)
        |-> high_side_switch == '0 && low_side_switch == '0)
        else $error("switches on in under-voltage");
    ov_drive_a: assert property (
        fault_latched.ov && !fault_latched.uv
        |-> ##[0:2] low_side_switch == '1 && high_side_switch == '0)
        else $error("wrong gates in over-voltage");
    fb_drive_a: assert property (
        fault_latched.fb && !fault_latched.uv
        |-> ##[0:2] low_side_switch == '1 && high_side_switch == '0)
        else $error("wrong gates in feedback fault");
    fault_sticky_a: assert property (
        supply_turnon_threshold && enable_released
        |=> (fault_latched & $past(fault_latched)) == $past(fault_latched))
        else $error("fault latch dropped");
    fault_pin_a: assert property (
        (|fault_latched) |=> fault_out)
        else $error("fault pin not raised");
    uv_qual_a: assert property (
        $rose(fault_latched.uv) |-> $past(cmp.under_voltage_trip)
        && $past(cmp.under_voltage_trip, 2))
        else $error("under-voltage not qualified");
    ov_mask_a: assert property (
        $rose(fault_latched.ov) |-> !$past(dynamic_reference_step))
        else $error("over-voltage not masked");
    pg_release_a: assert property (
        $fell(ramp_done_power_good_oe)
        |-> ref_level == target_ref && !ramp_done_power_good_o)
        else $error("released before ramp end");
    hold_mask_a: assert property (
        lowside_hold_startup && supply_turnon_threshold && !fault_out
        && fault_latched == '0 |-> low_side_switch == '0)
        else $error("low side on during hold");
endmodule
bind sfsq_seq sfsq_seq_chk i_chk (.*);

// *** test/tb_sfsq_seq.sv ***
// Self-checking bench of the soft-start and fault sequencer
`timescale 1ns/100ps
module tb_sfsq_seq;
    import sfsq_pkg::*;
    localparam int unsigned RL = 16;
    localparam int unsigned TL = 4;
    localparam logic [7:0] TRIP [3] = '{8'h80, 8'h40, 8'h01};
    localparam logic [2:0] GATE [3] = '{3'h0, 3'h7, 3'h7};
    localparam logic [1:0] PM [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2};
    localparam logic [7:0] PC [6] = '{8'h10, 8'h04, 8'h10, 8'h00, 8'h08, 8'h10};
    localparam logic [2:0] PL [6] = '{3'h0, 3'h7, 3'h7, 3'h7, 3'h0, 3'h7};
    logic        clk, arst_n, sup, pre, ena, step, hold, pg_o, pg_oe, flt;
    logic        pg_pin;
    logic [1:0]  stage_max, mode, mode_h;
    logic [7:0]  vid, vid_h;
    logic [11:0] ref_lvl;
    logic [2:0]  lhs, hs, ls;
    sfsq_cmp_t   cmp_in;
    sfsq_fault_t flt_l;
    int          num_errors = 0;
    int          num_checks = 0;
    sfsq_partner i_partner (.clk(clk), .arst_n(arst_n), .stage_max(stage_max),
        .pg_o(pg_o), .pg_oe(pg_oe), .pre_ok(pre), .supply_ok(sup),
        .enable_ok(ena), .pg_pin(pg_pin));
    sfsq_seq #(.RAMP_LEN(RL), .TAIL_LEN(TL)) i_dut (.clk(clk),
        .arst_n(arst_n), .supply_turnon_threshold(sup),
        .preprotect_supply_threshold(pre), .enable_released(ena),
        .mode_strap(mode), .vid_code(vid), .target_ref(12'h400),
        .uv_enable_ref(12'h100), .dynamic_reference_step(step),
        .loop_high_side(lhs), .loop_low_side(3'h7), .cmp(cmp_in),
        .ref_level(ref_lvl), .mode_held(mode_h), .vid_held(vid_h),
        .high_side_switch(hs), .low_side_switch(ls),
        .lowside_hold_startup(hold), .ramp_done_power_good_o(pg_o),
        .ramp_done_power_good_oe(pg_oe), .fault_out(flt),
        .fault_latched(flt_l));
    // ==========================================
    // Tasks
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        #1;
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic start_up;
        int n;
        @(posedge clk);
        lhs       <= 3'h0;
        cmp_in    <= 8'h80;
        vid       <= 8'h5a;
        mode      <= 2'h1;
        stage_max <= 2'h3;
        repeat (8) @(posedge clk);
        vid    <= 8'ha5;
        mode   <= 2'h2;
        cmp_in <= 8'h00;
        check(12'({pg_pin, hold, ls}), 12'h008);
        check(12'(flt_l), 12'h000);
        n = 0;
        while (pg_oe !== 1'b0 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(12'(n + 8 >= RL && n <= RL), 12'h1);
        check(ref_lvl, 12'h400);
        check(12'({hold, pg_pin, mode_h, vid_h}), 12'h55a);
        @(posedge clk) lhs <= 3'h7;
    endtask
    // ==========================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
    // ==========================================
    // Tests
    initial begin
        {arst_n, stage_max, mode, vid, step, lhs, cmp_in} = '0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        check(12'({pg_pin, flt}), 12'h0);
        start_up();
        @(posedge clk);
        step   <= 1'b1;
        cmp_in <= 8'he0;
        repeat (3) @(posedge clk);
        check(12'({pg_pin, flt}), 12'h2);
        @(posedge clk);
        cmp_in <= 8'h20;
        step   <= 1'b0;
        repeat (2) @(posedge clk);
        check(12'(pg_pin), 12'h1);
        repeat (TL + 2) @(posedge clk);
        check(12'({pg_pin, flt_l}), 12'h0);
        @(posedge clk) cmp_in <= 8'h20;
        repeat (3) @(posedge clk);
        check(12'(pg_pin), 12'h0);
        @(posedge clk) cmp_in <= 8'h00;
        stage_max <= 2'h2;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            start_up();
            if (i == 0) begin
                @(posedge clk) cmp_in <= 8'h80;
                @(posedge clk) cmp_in <= 8'h00;
                repeat (4) @(posedge clk);
                check(12'(flt_l), 12'h0);
            end
            @(posedge clk) cmp_in <= TRIP[i];
            repeat (3) @(posedge clk);
            cmp_in <= 8'h00;
            repeat (4) @(posedge clk);
            check(12'({flt, flt_l}), 12'(4'h8 | (3'h4 >> i)));
            check(12'({hs, ls}), 12'(GATE[i]));
            @(posedge clk) stage_max <= 2'h2;
            repeat (3) @(posedge clk);
            check(12'(flt_l), 12'h0);
        end
        @(posedge clk) stage_max <= 2'h1;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            mode   <= PM[i];
            cmp_in <= PC[i];
            repeat (3) @(posedge clk);
            check(12'(ls), 12'(PL[i]));
        end
        give_verdict();
    end
endmodule
